// *** core/dcb_can_node.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcb_can_node (
   input wire logic clk_i, // 100 MHz system clock
   input wire logic rst_i, // synchronous reset, active high
   input wire logic ce_i, // clock enable, freezes all state
   input wire logic wb_cyc_i, // wishbone cycle
   input wire logic wb_stb_i, // wishbone strobe
   input wire logic wb_we_i, // wishbone write enable
   input wire logic [7:0] wb_adr_i, // wishbone byte address
   input wire logic [3:0] wb_sel_i, // wishbone byte selects
   input wire logic [31:0] wb_dat_i, // wishbone write data
   output logic [31:0] wb_dat_o, // wishbone read data
   output logic wb_ack_o, // wishbone acknowledge
   input wire logic rx_valid_i, // received frame strobe
   input wire logic [10:0] rx_id_i, // received identifier
   input wire logic rx_rtr_i, // received remote request
   input wire logic [3:0] rx_dlc_i, // received byte count
   input wire logic [63:0] rx_data_i, // received payload, byte 0 low
   output logic tx_valid_o, // frame to send
   input wire logic tx_ready_i, // controller takes frame
   output logic [10:0] tx_id_o, // transmit identifier
   output logic [3:0] tx_dlc_o, // transmit byte count
   output logic [63:0] tx_data_o, // transmit payload, byte 0 low
   input wire logic [7:0] alarm_status_i, // current drive alarm
   output logic alarm_clear_o, // alarm clear pulse to drive
   output logic [15:0] bit_time_o, // active clocks per bit
   output logic [6:0] node_id_o, // active node address
   output logic [2:0] nmt_state_o // {stopped, operational, pre-op}
);
   // registers
   logic [15:0] can_bit_rate_code;
   logic [15:0] can_node_address;
   logic emcy_suppress;
   logic popup_request_bit;
   logic sync_seen;
   logic [31:0] popup_payload_pair;
   logic [63:0] blk_buf;
   logic [63:0] blk_param;
   logic [63:0] reply_param;
   // active configuration
   logic [2:0] act_rate;
   logic [6:0] act_node;
   // protocol state
   dcb_pkg::dcb_nmt_t nmt_st;
   logic guard_toggle;
   logic [7:0] alarm_prev;
   logic clr_pend;
   logic boot_pend, guard_pend, reply_pend, alarm_pend;
   logic [15:0] alarm_code_q;
   logic [7:0] alarm_q;
   logic [15:0] table_code;
   // decoded strobes
   logic wb_req, wr, rd;
   logic reinit_cmd, clr_cmd;
   logic rx_sync, rx_blk, rx_nmt, rx_guard, nmt_for_me;
   logic tx_take, ld_boot, ld_guard, ld_reply, ld_alarm, ld_popup;
   logic alarm_change;
   logic [31:0] rate_merged, node_merged;

   // byte-lane merge for wishbone writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   // clocks per bit for a rate code
   function automatic logic [15:0] bit_cycles(input logic [2:0] code);
      return 16'(dcb_pkg::CLK_KHZ / dcb_pkg::RATE_KBPS[code]);
   endfunction

   // emergency payload: code, error register, address, data
   function automatic logic [63:0] emcy_payload(input logic [15:0] code,
                                                input logic [6:0] node,
                                                input logic [31:0] dat);
      return {dat, {1'b0, node}, dcb_pkg::EMCY_ERR_REG, code};
   endfunction

   dcb_emcy_code u_code (
      .alarm_i(alarm_status_i),
      .code_o(table_code)
   );

   // bus and frame decode
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr = ce_i & wb_req & wb_we_i;
   assign rd = ce_i & wb_req & ~wb_we_i;
   assign rate_merged = merge({16'h0, can_bit_rate_code}, wb_dat_i, wb_sel_i);
   assign node_merged = merge({16'h0, can_node_address}, wb_dat_i, wb_sel_i);
   assign reinit_cmd = wr & (wb_adr_i == dcb_pkg::OFF_CTRL) & wb_sel_i[0]
      & wb_dat_i[dcb_pkg::CTRL_REINIT];
   assign clr_cmd = wr & (wb_adr_i == dcb_pkg::OFF_CTRL) & wb_sel_i[0]
      & wb_dat_i[dcb_pkg::CTRL_ALM_CLR];
   assign rx_sync = ce_i & rx_valid_i & ~rx_rtr_i & (rx_id_i == dcb_pkg::ID_SYNC)
      & (rx_dlc_i == 4'h0) & (nmt_st != dcb_pkg::NMT_STOPPED);
   assign rx_blk = ce_i & rx_valid_i & ~rx_rtr_i & (rx_dlc_i == 4'h8)
      & (rx_id_i == (dcb_pkg::ID_BLK_DATA | {7'h00, act_node[3:0]}))
      & (act_node[6:4] == 3'h0) & (nmt_st != dcb_pkg::NMT_STOPPED);
   assign rx_nmt = ce_i & rx_valid_i & ~rx_rtr_i & (rx_id_i == dcb_pkg::ID_NMT)
      & (rx_dlc_i == 4'h2);
   assign nmt_for_me = (rx_data_i[15:8] == 8'h00) | (rx_data_i[15:8] == {1'b0, act_node});
   assign rx_guard = ce_i & rx_valid_i & rx_rtr_i
      & (rx_id_i == (dcb_pkg::ID_GUARD | {4'h0, act_node}));
   assign alarm_change = ce_i & (alarm_status_i != alarm_prev);
   // transmit selection, fixed priority
   assign tx_take = ce_i & (~tx_valid_o | tx_ready_i);
   assign ld_boot = tx_take & boot_pend;
   assign ld_guard = tx_take & ~boot_pend & guard_pend;
   assign ld_reply = tx_take & ~boot_pend & ~guard_pend & reply_pend;
   assign ld_alarm = tx_take & ~boot_pend & ~guard_pend & ~reply_pend & alarm_pend;
   assign ld_popup = tx_take & ~boot_pend & ~guard_pend & ~reply_pend & ~alarm_pend
      & popup_request_bit & (nmt_st != dcb_pkg::NMT_STOPPED);

   // wishbone acknowledge, one cycle after request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else if (ce_i) begin
         wb_ack_o <= wb_req;
      end
   end

   // wishbone read data, unmapped reads zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (rd) begin
         case (wb_adr_i)
            dcb_pkg::OFF_BIT_RATE: wb_dat_o <= {16'h0000, can_bit_rate_code};
            dcb_pkg::OFF_NODE_ADDR: wb_dat_o <= {16'h0000, can_node_address};
            dcb_pkg::OFF_CTRL: wb_dat_o <= {29'h0, popup_request_bit, emcy_suppress, 1'b0};
            dcb_pkg::OFF_STATUS: wb_dat_o <= {4'h0, nmt_st, 5'h0, act_rate, 1'b0,
                                              act_node, 7'h0, sync_seen};
            dcb_pkg::OFF_POPUP: wb_dat_o <= popup_payload_pair;
            dcb_pkg::OFF_RX_LO: wb_dat_o <= blk_param[31:0];
            dcb_pkg::OFF_RX_HI: wb_dat_o <= blk_param[63:32];
            dcb_pkg::OFF_TX_LO: wb_dat_o <= reply_param[31:0];
            dcb_pkg::OFF_TX_HI: wb_dat_o <= reply_param[63:32];
            default: wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // configuration registers, stored but not yet active
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         can_bit_rate_code <= dcb_pkg::RST_BIT_RATE;
         can_node_address <= dcb_pkg::RST_NODE_ADDR;
      end else if (wr) begin
         if (wb_adr_i == dcb_pkg::OFF_BIT_RATE) begin
            can_bit_rate_code <= rate_merged[15:0];
         end
         if ((wb_adr_i == dcb_pkg::OFF_NODE_ADDR)
             && (node_merged[15:0] <= dcb_pkg::NODE_ADDR_MAX)) begin
            can_node_address <= node_merged[15:0];
         end
      end
   end

   // active rate and address follow registers on reinit only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         act_rate <= dcb_pkg::RST_BIT_RATE[2:0];
         act_node <= dcb_pkg::RST_NODE_ADDR[6:0];
         bit_time_o <= bit_cycles(dcb_pkg::RST_BIT_RATE[2:0]);
      end else if (reinit_cmd) begin
         act_rate <= can_bit_rate_code[2:0];
         act_node <= can_node_address[6:0];
         bit_time_o <= bit_cycles(can_bit_rate_code[2:0]);
      end
   end

   // node id output
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         node_id_o <= dcb_pkg::RST_NODE_ADDR[6:0];
      end else if (ce_i) begin
         node_id_o <= act_node;
      end
   end

   // control bits, popup self-clears when its frame is loaded
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         emcy_suppress <= 1'b0;
         popup_request_bit <= 1'b0;
         popup_payload_pair <= 32'h0000_0000;
      end else begin
         if (ld_popup) begin
            popup_request_bit <= 1'b0;
         end
         if (wr && (wb_adr_i == dcb_pkg::OFF_CTRL) && wb_sel_i[0]) begin
            emcy_suppress <= wb_dat_i[dcb_pkg::CTRL_SUPPRESS];
            if (wb_dat_i[dcb_pkg::CTRL_POPUP]) begin
               popup_request_bit <= 1'b1;
            end
         end
         if (wr && (wb_adr_i == dcb_pkg::OFF_POPUP)) begin
            popup_payload_pair <= merge(popup_payload_pair, wb_dat_i, wb_sel_i);
         end
      end
   end

   // sync-seen flag, write one clears, new sync wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync_seen <= 1'b0;
      end else if (rx_sync) begin
         sync_seen <= 1'b1;
      end else if (wr && (wb_adr_i == dcb_pkg::OFF_STATUS) && wb_sel_i[0]
                   && wb_dat_i[dcb_pkg::STAT_SYNC]) begin
         sync_seen <= 1'b0;
      end
   end

   // block buffer, parameter commit and reply parameters
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         blk_buf <= 64'h0;
         blk_param <= 64'h0;
         reply_param <= 64'h0;
      end else begin
         if (rx_blk) begin
            blk_buf <= rx_data_i;
         end
         if (rx_sync) begin
            blk_param <= blk_buf;
         end
         if (wr && (wb_adr_i == dcb_pkg::OFF_TX_LO)) begin
            reply_param[31:0] <= merge(reply_param[31:0], wb_dat_i, wb_sel_i);
         end
         if (wr && (wb_adr_i == dcb_pkg::OFF_TX_HI)) begin
            reply_param[63:32] <= merge(reply_param[63:32], wb_dat_i, wb_sel_i);
         end
      end
   end

   // network management state machine
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         nmt_st <= dcb_pkg::NMT_INIT;
      end else if (ce_i) begin
         case (nmt_st)
            dcb_pkg::NMT_INIT: nmt_st <= dcb_pkg::NMT_PRE;
            dcb_pkg::NMT_PRE, dcb_pkg::NMT_OP, dcb_pkg::NMT_STOPPED: begin
               if (reinit_cmd) begin
                  nmt_st <= dcb_pkg::NMT_INIT;
               end else if (rx_nmt && nmt_for_me) begin
                  case (rx_data_i[7:0])
                     dcb_pkg::NMT_START: nmt_st <= dcb_pkg::NMT_OP;
                     dcb_pkg::NMT_STOP: nmt_st <= dcb_pkg::NMT_STOPPED;
                     dcb_pkg::NMT_PREOP: nmt_st <= dcb_pkg::NMT_PRE;
                     dcb_pkg::NMT_RST_NODE, dcb_pkg::NMT_RST_COMM: nmt_st <= dcb_pkg::NMT_INIT;
                     default: nmt_st <= nmt_st;
                  endcase
               end
            end
            default: nmt_st <= dcb_pkg::NMT_INIT;
         endcase
      end
   end

   // nmt state output
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         nmt_state_o <= 3'b000;
      end else if (ce_i) begin
         nmt_state_o <= {nmt_st == dcb_pkg::NMT_STOPPED, nmt_st == dcb_pkg::NMT_OP,
                         nmt_st == dcb_pkg::NMT_PRE};
      end
   end

   // boot-up, guard and reply requests, new request wins over load
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         boot_pend <= 1'b0;
         guard_pend <= 1'b0;
         reply_pend <= 1'b0;
         guard_toggle <= 1'b0;
      end else if (ce_i) begin
         if (ld_boot) boot_pend <= 1'b0;
         if (ld_guard) guard_pend <= 1'b0;
         if (ld_reply) reply_pend <= 1'b0;
         if (ld_guard) guard_toggle <= ~guard_toggle;
         if (nmt_st == dcb_pkg::NMT_INIT) begin
            boot_pend <= 1'b1;
            guard_toggle <= 1'b0;
         end
         if (rx_guard) guard_pend <= 1'b1;
         if (rx_sync) reply_pend <= 1'b1;
      end
   end

   // alarm change tracking for emergency frames
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         alarm_prev <= 8'h00;
         alarm_pend <= 1'b0;
         alarm_q <= 8'h00;
         alarm_code_q <= 16'h0000;
         clr_pend <= 1'b0;
         alarm_clear_o <= 1'b0;
      end else if (ce_i) begin
         alarm_prev <= alarm_status_i;
         alarm_clear_o <= clr_cmd;
         if (ld_alarm) alarm_pend <= 1'b0;
         if (alarm_change) begin
            clr_pend <= 1'b0;
            alarm_q <= alarm_status_i;
            alarm_code_q <= clr_pend ? dcb_pkg::EMCY_CODE_CLEAR : table_code;
            if (!emcy_suppress) alarm_pend <= 1'b1;
         end
         if (clr_cmd) clr_pend <= 1'b1;
      end
   end

   // transmit frame register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_valid_o <= 1'b0;
         tx_id_o <= 11'h000;
         tx_dlc_o <= 4'h0;
         tx_data_o <= 64'h0;
      end else if (tx_take) begin
         tx_valid_o <= ld_boot | ld_guard | ld_reply | ld_alarm | ld_popup;
         if (ld_boot) begin
            tx_id_o <= dcb_pkg::ID_GUARD | {4'h0, act_node};
            tx_dlc_o <= 4'h1;
            tx_data_o <= 64'h0;
         end else if (ld_guard) begin
            tx_id_o <= dcb_pkg::ID_GUARD | {4'h0, act_node};
            tx_dlc_o <= 4'h1;
            tx_data_o <= {56'h0, guard_toggle,
                          (nmt_st == dcb_pkg::NMT_OP) ? dcb_pkg::NMT_ST_OPER :
                          (nmt_st == dcb_pkg::NMT_STOPPED) ? dcb_pkg::NMT_ST_STOP :
                          dcb_pkg::NMT_ST_PREOP};
         end else if (ld_reply) begin
            tx_id_o <= dcb_pkg::ID_BLK_REPLY | {7'h00, act_node[3:0]};
            tx_dlc_o <= 4'h8;
            tx_data_o <= reply_param;
         end else if (ld_alarm) begin
            tx_id_o <= dcb_pkg::ID_EMCY | {4'h0, act_node};
            tx_dlc_o <= 4'h8;
            tx_data_o <= emcy_payload(alarm_code_q, act_node, {24'h0, alarm_q});
         end else if (ld_popup) begin
            tx_id_o <= dcb_pkg::ID_EMCY | {4'h0, act_node};
            tx_dlc_o <= 4'h8;
            tx_data_o <= emcy_payload(dcb_pkg::EMCY_CODE_POPUP, act_node,
                                      popup_payload_pair);
         end
      end
   end
endmodule
`default_nettype wire

// *** core/dcb_emcy_code.sv ***
`timescale 1ns/1ps
`default_nettype none
// maps a drive alarm number to its emergency error code
module dcb_emcy_code (
   input wire logic [7:0] alarm_i, // alarm number
   output logic [15:0] code_o // emergency error code
);
   // per-alarm lookup, unknown alarms give a generic device code
   always_comb begin
      case (alarm_i)
         8'h01: code_o = 16'h3210;
         8'h02: code_o = 16'h3220;
         8'h03: code_o = 16'h2340;
         8'h04: code_o = 16'h7310;
         8'h05: code_o = 16'hff07;
         8'h06: code_o = 16'h4310;
         8'h07: code_o = 16'hff00;
         8'h08: code_o = 16'hff01;
         8'h0a: code_o = 16'h6310;
         8'h0b: code_o = 16'h6310;
         8'h0f: code_o = 16'h6320;
         8'h10: code_o = 16'hff03;
         8'h11: code_o = 16'hff08;
         8'h14: code_o = 16'hff0a;
         8'h15: code_o = 16'h5112;
         8'h16: code_o = 16'h4110;
         8'h17: code_o = 16'hff0c;
         8'h18: code_o = 16'hff0d;
         8'h19: code_o = 16'hff0e;
         8'h1a: code_o = 16'hff0f;
         8'h1c: code_o = 16'h7320;
         8'h00: code_o = 16'h0000;
         default: code_o = 16'h1000;
      endcase
   end
endmodule
`default_nettype wire

// *** shared/dcb_pkg.sv ***
package dcb_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_BIT_RATE = 8'h00;
   localparam logic [7:0] OFF_NODE_ADDR = 8'h04;
   localparam logic [7:0] OFF_CTRL = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0c;
   localparam logic [7:0] OFF_POPUP = 8'h10;
   localparam logic [7:0] OFF_RX_LO = 8'h14;
   localparam logic [7:0] OFF_RX_HI = 8'h18;
   localparam logic [7:0] OFF_TX_LO = 8'h1c;
   localparam logic [7:0] OFF_TX_HI = 8'h20;
   // control register bits
   localparam int CTRL_REINIT = 0;
   localparam int CTRL_SUPPRESS = 1;
   localparam int CTRL_POPUP = 2;
   localparam int CTRL_ALM_CLR = 3;
   // status register bits
   localparam int STAT_SYNC = 0;
   // reset values and node address limit
   localparam logic [15:0] RST_BIT_RATE = 16'h0001;
   localparam logic [15:0] RST_NODE_ADDR = 16'h0001;
   localparam logic [15:0] NODE_ADDR_MAX = 16'h007f;
   // identifiers
   localparam logic [10:0] ID_NMT = 11'h000;
   localparam logic [10:0] ID_SYNC = 11'h400;
   localparam logic [10:0] ID_BLK_DATA = 11'h410;
   localparam logic [10:0] ID_BLK_REPLY = 11'h420;
   localparam logic [10:0] ID_EMCY = 11'h080;
   localparam logic [10:0] ID_GUARD = 11'h700;
   // emergency contents
   localparam logic [7:0] EMCY_ERR_REG = 8'h01;
   localparam logic [15:0] EMCY_CODE_CLEAR = 16'h0000;
   localparam logic [15:0] EMCY_CODE_POPUP = 16'hff09;
   // network management commands and states
   localparam logic [7:0] NMT_START = 8'h01;
   localparam logic [7:0] NMT_STOP = 8'h02;
   localparam logic [7:0] NMT_PREOP = 8'h80;
   localparam logic [7:0] NMT_RST_NODE = 8'h81;
   localparam logic [7:0] NMT_RST_COMM = 8'h82;
   localparam logic [6:0] NMT_ST_STOP = 7'h04;
   localparam logic [6:0] NMT_ST_OPER = 7'h05;
   localparam logic [6:0] NMT_ST_PREOP = 7'h7f;
   // bit rates in kbit/s, indexed by rate code
   localparam int CLK_KHZ = 100000;
   localparam int RATE_KBPS [8] = '{125, 1000, 500, 250, 125, 50, 20, 10};
   typedef enum logic [3:0] {
      NMT_INIT = 4'b0001,
      NMT_PRE = 4'b0010,
      NMT_OP = 4'b0100,
      NMT_STOPPED = 4'b1000
   } dcb_nmt_t;
endpackage

// *** verif/dcb_can_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcb_can_ctrl_model (
   input wire logic clk_i, // clock
   input wire logic [3:0] stall_i, // idle cycles before ready
   output logic rx_valid_o, // frame strobe
   output logic [10:0] rx_id_o, // identifier
   output logic rx_rtr_o, // remote request
   output logic [3:0] rx_dlc_o, // byte count
   output logic [63:0] rx_data_o, // payload
   input wire logic tx_valid_i, // frame offered
   output logic tx_ready_o, // frame taken
   input wire logic [10:0] tx_id_i, // identifier
   input wire logic [3:0] tx_dlc_i, // byte count
   input wire logic [63:0] tx_data_i // payload
);
   logic [3:0] wait_cnt = 4'h0;
   logic [78:0] q[$];
   initial begin
      rx_valid_o = 1'b0;
      rx_id_o = 11'h7ff;
      rx_rtr_o = 1'b1;
      rx_dlc_o = 4'hf;
      rx_data_o = 64'h0;
      tx_ready_o = 1'b0;
   end
   // ready after a programmable stall, every taken frame logged
   always @(posedge clk_i) begin
      if (!tx_valid_i || tx_ready_o) begin
         wait_cnt <= 4'h0;
         tx_ready_o <= 1'b0;
      end else if (wait_cnt >= stall_i) begin
         tx_ready_o <= 1'b1;
      end else begin
         wait_cnt <= wait_cnt + 4'h1;
      end
      if (tx_valid_i && tx_ready_o) begin
         q.push_back({tx_id_i, tx_dlc_i, tx_data_i});
      end
   end
   // one-cycle strobe, lines scrambled once released
   task automatic send(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] d);
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_id_o <= id;
      rx_rtr_o <= 1'b0;
      rx_dlc_o <= dlc;
      rx_data_o <= d;
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      rx_id_o <= ~id;
      rx_rtr_o <= 1'b1;
      rx_dlc_o <= ~dlc;
      rx_data_o <= ~d;
   endtask
   task automatic send_block(input logic [3:0] adr, input logic [63:0] d);
      send({7'h41, adr}, 4'h8, d);
   endtask
   task automatic send_sync();
      send(11'h400, 4'h0, 64'h0);
   endtask
endmodule
`default_nettype wire

// *** verif/dcb_can_node_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcb_can_node_props (
   input wire logic clk_i, // clock
   input wire logic rst_i, // reset
   input wire logic ce_i, // enable
   input wire logic wb_cyc_i, // cycle
   input wire logic wb_stb_i, // strobe
   input wire logic wb_ack_o, // ack
   input wire logic rx_valid_i, // rx strobe
   input wire logic [10:0] rx_id_i, // rx id
   input wire logic [3:0] rx_dlc_i, // rx count
   input wire logic tx_valid_o, // tx valid
   input wire logic tx_ready_i, // tx ready
   input wire logic [10:0] tx_id_o, // tx id
   input wire logic [3:0] tx_dlc_o, // tx count
   input wire logic [63:0] tx_data_o, // tx payload
   input wire logic alarm_clear_o, // clear pulse
   input wire logic [15:0] bit_time_o, // bit time
   input wire logic [6:0] node_id_o, // node
   input wire logic [2:0] nmt_state_o // nmt state
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // bus answer, frame hold, frame layouts, rate table
   property p_ack;
      wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("ack late");
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   property p_tx_hold;
      tx_valid_o && !tx_ready_i && ce_i |=> tx_valid_o && $stable(tx_id_o) && $stable(tx_data_o);
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("frame dropped");
   property p_sync_reply;
      rx_valid_i && ce_i && rx_id_i == dcb_pkg::ID_SYNC && rx_dlc_i == 4'h0 && !nmt_state_o[2]
         |-> ##[1:60] tx_valid_o && tx_id_o[10:4] == 7'h42;
   endproperty
   a_sync_reply: assert property (p_sync_reply) else $error("no reply");
   property p_reply_fmt;
      tx_valid_o && tx_id_o[10:4] == 7'h42 |-> tx_dlc_o == 4'h8 && tx_id_o[3:0] == node_id_o[3:0];
   endproperty
   a_reply_fmt: assert property (p_reply_fmt) else $error("bad reply");
   property p_emcy_fmt;
      tx_valid_o && tx_id_o[10:7] == 4'h1 |-> tx_id_o[6:0] == node_id_o && tx_dlc_o == 4'h8
         && tx_data_o[23:16] == 8'h01 && tx_data_o[31:24] == {1'b0, node_id_o};
   endproperty
   a_emcy_fmt: assert property (p_emcy_fmt) else $error("bad emergency");
   property p_rate;
      bit_time_o inside {16'h0320, 16'h0064, 16'h00c8, 16'h0190, 16'h07d0, 16'h1388, 16'h2710};
   endproperty
   a_rate: assert property (p_rate) else $error("bad bit time");
   property p_clr_pulse;
      alarm_clear_o |=> !alarm_clear_o;
   endproperty
   a_clr_pulse: assert property (p_clr_pulse) else $error("clear too long");
   c_reply: cover property (tx_valid_o && tx_ready_i && tx_id_o[10:4] == 7'h42);
   c_emcy: cover property (tx_valid_o && tx_ready_i && tx_id_o[10:7] == 4'h1);
   c_stall: cover property (tx_valid_o && !tx_ready_i ##1 tx_valid_o && !tx_ready_i);
endmodule
bind dcb_can_node dcb_can_node_props i_props (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .rx_valid_i(rx_valid_i),
   .rx_id_i(rx_id_i), .rx_dlc_i(rx_dlc_i), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
   .tx_id_o(tx_id_o), .tx_dlc_o(tx_dlc_o), .tx_data_o(tx_data_o), .alarm_clear_o(alarm_clear_o),
   .bit_time_o(bit_time_o), .node_id_o(node_id_o), .nmt_state_o(nmt_state_o));
`default_nettype wire

// *** verif/dcb_can_node_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcb_can_node_tb_top;
   logic clk = 1'b0, rst = 1'b1, ce = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00, alarm = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, rd;
   logic [3:0] stall = 4'h0, rxdlc, txdlc;
   logic [10:0] rxid, txid;
   logic [63:0] rxd, txd;
   logic [15:0] btime, bt;
   logic [6:0] node;
   logic [2:0] nmt;
   logic ack, rxv, rxrtr, txv, txr, aclr;
   int n_mismatch = 0, check_count = 0, n_clr = 0;
   localparam logic [78:0] REP = {11'h421, 4'h8, 64'h5566778811223344};
   // clock
   always #5 clk = ~clk;
   // alarm clear pulses seen
   always @(posedge clk) begin
      if (aclr === 1'b1) n_clr++;
   end
   dcb_can_node i_dut (.clk_i(clk), .rst_i(rst), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .rx_valid_i(rxv), .rx_id_i(rxid), .rx_rtr_i(rxrtr), .rx_dlc_i(rxdlc),
      .rx_data_i(rxd), .tx_valid_o(txv), .tx_ready_i(txr), .tx_id_o(txid), .tx_dlc_o(txdlc),
      .tx_data_o(txd), .alarm_status_i(alarm), .alarm_clear_o(aclr), .bit_time_o(btime),
      .node_id_o(node), .nmt_state_o(nmt));
   dcb_can_ctrl_model i_can (.clk_i(clk), .stall_i(stall), .rx_valid_o(rxv), .rx_id_o(rxid),
      .rx_rtr_o(rxrtr), .rx_dlc_o(rxdlc), .rx_data_o(rxd), .tx_valid_i(txv), .tx_ready_o(txr),
      .tx_id_i(txid), .tx_dlc_i(txdlc), .tx_data_i(txd));
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic check(input logic [79:0] seen, input logic [79:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic hang();
      n_mismatch++;
      print_verdict();
   endtask
   // one classic cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) hang();
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   // next frame taken by the controller
   task automatic frame(input logic [78:0] f);
      int n;
      for (n = 0; n < 400 && i_can.q.size() == 0; n++) @(posedge clk);
      if (i_can.q.size() == 0) hang();
      check(i_can.q.pop_front(), f);
   endtask
   function automatic logic [78:0] emcy(input logic [15:0] c, input logic [31:0] d);
      return {11'h085, 4'h8, d, 8'h05, 8'h01, c};
   endfunction
   task automatic s_block();
      wb(1'b1, dcb_pkg::OFF_TX_LO, 32'h11223344);
      wb(1'b1, dcb_pkg::OFF_TX_HI, 32'h55667788);
      i_can.send_block(4'h1, 64'ha1a2a3a4a5a6a7a8);
      i_can.send_block(4'h2, 64'hbad0bad0bad0bad0);
      i_can.send_sync();
      frame(REP);
      wb(1'b0, dcb_pkg::OFF_RX_LO, 32'h0);
      check(rd, 32'ha5a6a7a8);
      wb(1'b0, dcb_pkg::OFF_STATUS, 32'h0);
      check(rd[0], 1'b1);
      i_can.send_block(4'h1, 64'hc1c2c3c4c5c6c7c8);
      wb(1'b0, dcb_pkg::OFF_RX_HI, 32'h0);
      check(rd, 32'ha1a2a3a4);
      i_can.send_sync();
      frame(REP);
      i_can.send_sync();
      frame(REP);
      wb(1'b0, dcb_pkg::OFF_RX_LO, 32'h0);
      check(rd, 32'hc5c6c7c8);
   endtask
   task automatic s_config();
      for (int c = 0; c < 8; c++) begin
         bt = btime;
         wb(1'b1, dcb_pkg::OFF_BIT_RATE, 32'(c));
         check(btime, bt);
         wb(1'b1, dcb_pkg::OFF_CTRL, 32'h1);
         frame({11'h701, 4'h1, 64'h0});
         check(btime, 16'(100000 / dcb_pkg::RATE_KBPS[c]));
      end
      wb(1'b1, dcb_pkg::OFF_NODE_ADDR, 32'h5);
      wb(1'b1, dcb_pkg::OFF_NODE_ADDR, 32'hc8);
      wb(1'b0, dcb_pkg::OFF_NODE_ADDR, 32'h0);
      check(rd, 32'h5);
      check(node, 7'h1);
      wb(1'b1, dcb_pkg::OFF_CTRL, 32'h1);
      frame({11'h705, 4'h1, 64'h0});
      check(node, 7'h5);
   endtask
   task automatic s_alarm();
      alarm <= 8'h01;
      frame(emcy(16'h3210, 32'h1));
      alarm <= 8'h03;
      frame(emcy(16'h2340, 32'h3));
      wb(1'b1, dcb_pkg::OFF_CTRL, 32'h8);
      check(n_clr, 1);
      alarm <= 8'h02;
      frame(emcy(16'h0000, 32'h2));
      wb(1'b1, dcb_pkg::OFF_CTRL, 32'h2);
      alarm <= 8'h04;
      repeat (30) @(posedge clk);
      check(i_can.q.size(), 0);
      wb(1'b1, dcb_pkg::OFF_CTRL, 32'h0);
      alarm <= 8'h1c;
      frame(emcy(16'h7320, 32'h1c));
      stall <= 4'h3;
      wb(1'b1, dcb_pkg::OFF_POPUP, 32'hcafe0123);
      wb(1'b1, dcb_pkg::OFF_CTRL, 32'h4);
      frame(emcy(16'hff09, 32'hcafe0123));
      wb(1'b0, dcb_pkg::OFF_CTRL, 32'h0);
      check(rd[2], 1'b0);
   endtask
   task automatic s_nmt();
      i_can.send(11'h000, 4'h2, 64'h0502);
      repeat (2) @(posedge clk);
      check(nmt, 3'b100);
      i_can.send_sync();
      repeat (20) @(posedge clk);
      check(i_can.q.size(), 0);
      i_can.send(11'h000, 4'h2, 64'h0501);
      repeat (2) @(posedge clk);
      check(nmt, 3'b010);
   endtask
   // reset, defaults, then the scenarios
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      frame({11'h701, 4'h1, 64'h0});
      wb(1'b0, dcb_pkg::OFF_BIT_RATE, 32'h0);
      check(rd, 32'h1);
      wb(1'b0, dcb_pkg::OFF_NODE_ADDR, 32'h0);
      check(rd, 32'h1);
      check(btime, 16'h0064);
      wb(1'b0, 8'hfc, 32'h0);
      check(rd, 32'h0);
      s_block();
      s_config();
      s_alarm();
      s_nmt();
      print_verdict();
   end
endmodule
`default_nettype wire
